// [adc_cal_pkg.sv]
// Constants and types for the calibration and sampling sequencer
package adc_cal_pkg;

   // -------------------------------------------------------------
   // Sampling timing, in master clock cycles
   // -------------------------------------------------------------
   localparam int SAMPLE_PERIOD_CYC = 256;
   localparam int SETTLE_CYC = 62;
   localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_PERIOD_CYC - 1);
   localparam logic [5:0] SETTLE_LOAD = 6'(SETTLE_CYC);

   // -------------------------------------------------------------
   // Calibration timing, in master clock cycles
   // -------------------------------------------------------------
   localparam int STROBE_MIN_CYC = 4;
   localparam logic [2:0] STROBE_MIN = 3'(STROBE_MIN_CYC);
   localparam int SELF_CAL_CYC = 3145655;
   localparam int SYS_OFFSET_CYC = 1052599;
   localparam int SYS_GAIN_CYC = 1068813;
   localparam int SYS_ONE_STEP_CYC = 2117389;
   localparam int FILTER_SETTLE_CYC = 507904;
   localparam int CNT_W = 22;
   typedef logic [CNT_W-1:0] cal_cnt_t;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic WORD_VALID_N_RST = 1'b1;
   localparam cal_cnt_t CNT_RST = 22'h000000;

   // -------------------------------------------------------------
   // Calibration type, coded as {select_a, select_b}
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      CAL_SELF = 2'h0,
      CAL_SYS_GAIN = 2'h1,
      CAL_SYS_ONE = 2'h2,
      CAL_SYS_OFFSET = 2'h3
   } cal_type_t;

   // -------------------------------------------------------------
   // Sequencer states
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_CAL = 3'h2,
      ST_SETTLE = 3'h4
   } seq_state_t;

endpackage

// [adc_calibration_sequencer.sv]
// Calibration sequencer and input sampling timing for the converter
// How it works
// - Sample input once per 256 clocks
// - Hold 62 settling clocks after each sample
// - Selects 00: self-cal, 3,145,655 clocks
// - Selects 11: offset step, 1,052,599 clocks
// - Selects 01: gain step, 1,068,813 clocks
// - Selects 10: one-step offset, 2,117,389 clocks
// - Self-cal uses ground and reference pins
// - Bipolar: calibrate midscale and positive full scale
// - System steps take the zero point or full scale from input; one-step takes zero only
// - Coefficients kept in on-chip storage
// - Word-valid stays high throughout calibration
// - Self-cal waits settling; others fall immediately
`timescale 1ns/10ps
`default_nettype none

module adc_calibration_sequencer #(
   parameter int unsigned SELF_CAL_CYC = adc_cal_pkg::SELF_CAL_CYC,
   parameter int unsigned SYS_OFFSET_CYC = adc_cal_pkg::SYS_OFFSET_CYC,
   parameter int unsigned SYS_GAIN_CYC = adc_cal_pkg::SYS_GAIN_CYC,
   parameter int unsigned SYS_ONE_STEP_CYC =
      adc_cal_pkg::SYS_ONE_STEP_CYC,
   parameter int unsigned FILTER_SETTLE_CYC =
      adc_cal_pkg::FILTER_SETTLE_CYC
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Calibration control from the host
   input wire logic CAL_STROBE,
   input wire logic TRIM_TYPE_SELECT_A,
   input wire logic TRIM_TYPE_SELECT_B,
   input wire logic BIPOLAR_MODE,
   // Sampling timing
   output logic SAMPLE_STROBE,
   output logic INPUT_SETTLING,
   // Calibration status and routing
   output logic OUTPUT_WORD_VALID_N,
   output logic CAL_BUSY,
   output logic ZERO_STEP_ACTIVE,
   output logic FS_STEP_ACTIVE,
   output logic ZERO_REF_IS_AIN,
   output logic FS_REF_IS_AIN,
   output logic MIDSCALE_CAL,
   // Stored coefficient state
   output logic ZERO_COEF_VALID,
   output logic FS_COEF_VALID,
   output logic ZERO_COEF_FROM_AIN,
   output logic FS_COEF_FROM_AIN
);

   // -------------------------------------------------------------
   // Parameter checks
   // -------------------------------------------------------------
   localparam longint unsigned CNT_MAX = 64'd1 << adc_cal_pkg::CNT_W;
   if (SELF_CAL_CYC < 1 || SELF_CAL_CYC >= CNT_MAX ||
       SYS_OFFSET_CYC < 1 || SYS_OFFSET_CYC >= CNT_MAX ||
       SYS_GAIN_CYC < 1 || SYS_GAIN_CYC >= CNT_MAX ||
       SYS_ONE_STEP_CYC < 1 || SYS_ONE_STEP_CYC >= CNT_MAX ||
       FILTER_SETTLE_CYC < 1 || FILTER_SETTLE_CYC >= CNT_MAX) begin : g_chk
      $error("Cycle counts must lie between 1 and 2**22-1");
   end
   // Counter load values, one less than each duration
   localparam adc_cal_pkg::cal_cnt_t SELF_LD =
      adc_cal_pkg::cal_cnt_t'(SELF_CAL_CYC - 1);
   localparam adc_cal_pkg::cal_cnt_t OFFSET_LD =
      adc_cal_pkg::cal_cnt_t'(SYS_OFFSET_CYC - 1);
   localparam adc_cal_pkg::cal_cnt_t GAIN_LD =
      adc_cal_pkg::cal_cnt_t'(SYS_GAIN_CYC - 1);
   localparam adc_cal_pkg::cal_cnt_t ONE_LD =
      adc_cal_pkg::cal_cnt_t'(SYS_ONE_STEP_CYC - 1);
   localparam adc_cal_pkg::cal_cnt_t FILT_LD =
      adc_cal_pkg::cal_cnt_t'(FILTER_SETTLE_CYC - 1);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      adc_cal_pkg::seq_state_t state;
      adc_cal_pkg::cal_type_t cal_type;
      adc_cal_pkg::cal_cnt_t cnt;
      logic [2:0] strobe_cnt;
      logic strobe_q;
      logic [7:0] samp_cnt;
      logic [5:0] settle_cnt;
      logic sample;
      logic settling;
      logic word_valid_n;
      logic busy;
      logic zero_active;
      logic fs_active;
      logic zero_ain;
      logic fs_ain;
      logic midscale;
      logic zero_valid;
      logic fs_valid;
      logic zero_from_ain;
      logic fs_from_ain;
   } seq_t;
   localparam seq_t SEQ_RST = '{
      state: adc_cal_pkg::ST_IDLE,
      cal_type: adc_cal_pkg::CAL_SELF,
      cnt: adc_cal_pkg::CNT_RST,
      word_valid_n: adc_cal_pkg::WORD_VALID_N_RST,
      default: '0
   };
   seq_t s_ff;
   seq_t nxt_s;
   logic cal_start;
   logic cal_done;
   adc_cal_pkg::cal_type_t sel_type;
   // Strobe accepted on its falling edge after a long enough high
   assign sel_type = adc_cal_pkg::cal_type_t'(
      {TRIM_TYPE_SELECT_A, TRIM_TYPE_SELECT_B});
   assign cal_start = s_ff.strobe_q && !CAL_STROBE &&
      s_ff.strobe_cnt >= adc_cal_pkg::STROBE_MIN;
   assign cal_done = s_ff.state == adc_cal_pkg::ST_CAL &&
      s_ff.cnt == adc_cal_pkg::CNT_RST;

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.sample = 1'b0;
      nxt_s.strobe_q = CAL_STROBE;
      // Strobe high-time count, saturating
      if (!CAL_STROBE) begin
         nxt_s.strobe_cnt = 3'h0;
      end else if (s_ff.strobe_cnt < adc_cal_pkg::STROBE_MIN) begin
         nxt_s.strobe_cnt = s_ff.strobe_cnt + 3'h1;
      end
      // Settling window runs down
      if (s_ff.settle_cnt != 6'h00) begin
         nxt_s.settle_cnt = s_ff.settle_cnt - 6'h01;
      end
      if (s_ff.samp_cnt == adc_cal_pkg::SAMPLE_LAST) begin
         nxt_s.samp_cnt = 8'h00;
         nxt_s.sample = 1'b1;
         nxt_s.settle_cnt = adc_cal_pkg::SETTLE_LOAD;
      end else begin
         nxt_s.samp_cnt = s_ff.samp_cnt + 8'h01;
      end
      nxt_s.settling = nxt_s.settle_cnt != 6'h00;
      // Calibration sequence; a new strobe restarts it
      if (cal_start) begin
         nxt_s.state = adc_cal_pkg::ST_CAL;
         nxt_s.cal_type = sel_type;
         nxt_s.word_valid_n = 1'b1;
         nxt_s.zero_active = 1'b0;
         nxt_s.fs_active = 1'b0;
         nxt_s.zero_ain = 1'b0;
         nxt_s.fs_ain = 1'b0;
         unique case (sel_type)
            adc_cal_pkg::CAL_SELF: begin
               nxt_s.cnt = SELF_LD;
               nxt_s.zero_active = 1'b1;
               nxt_s.fs_active = 1'b1;
            end
            adc_cal_pkg::CAL_SYS_OFFSET: begin
               nxt_s.cnt = OFFSET_LD;
               nxt_s.zero_active = 1'b1;
               nxt_s.zero_ain = 1'b1;
            end
            adc_cal_pkg::CAL_SYS_GAIN: begin
               nxt_s.cnt = GAIN_LD;
               nxt_s.fs_active = 1'b1;
               nxt_s.fs_ain = 1'b1;
            end
            adc_cal_pkg::CAL_SYS_ONE: begin
               nxt_s.cnt = ONE_LD;
               nxt_s.zero_active = 1'b1;
               nxt_s.fs_active = 1'b1;
               nxt_s.zero_ain = 1'b1;
            end
         endcase
      end else begin
         unique case (s_ff.state)
            adc_cal_pkg::ST_IDLE: ;
            adc_cal_pkg::ST_CAL: begin
               if (cal_done) begin
                  nxt_s.zero_active = 1'b0;
                  nxt_s.fs_active = 1'b0;
                  nxt_s.zero_ain = 1'b0;
                  nxt_s.fs_ain = 1'b0;
                  if (s_ff.zero_active) begin
                     nxt_s.zero_valid = 1'b1;
                     nxt_s.zero_from_ain = s_ff.zero_ain;
                  end
                  if (s_ff.fs_active) begin
                     nxt_s.fs_valid = 1'b1;
                     nxt_s.fs_from_ain = s_ff.fs_ain;
                  end
                  if (s_ff.cal_type == adc_cal_pkg::CAL_SELF) begin
                     nxt_s.state = adc_cal_pkg::ST_SETTLE;
                     nxt_s.cnt = FILT_LD;
                  end else begin
                     nxt_s.state = adc_cal_pkg::ST_IDLE;
                     nxt_s.word_valid_n = 1'b0;
                  end
               end else begin
                  nxt_s.cnt = s_ff.cnt - 22'h000001;
               end
            end
            adc_cal_pkg::ST_SETTLE: begin
               // falls once settled to the input
               if (s_ff.cnt == adc_cal_pkg::CNT_RST) begin
                  nxt_s.state = adc_cal_pkg::ST_IDLE;
                  nxt_s.word_valid_n = 1'b0;
               end else begin
                  nxt_s.cnt = s_ff.cnt - 22'h000001;
               end
            end
         endcase
      end
      nxt_s.midscale = nxt_s.zero_active && BIPOLAR_MODE;
      nxt_s.busy = nxt_s.state != adc_cal_pkg::ST_IDLE;
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_ff <= SEQ_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end
   // Outputs straight from the state register
   assign SAMPLE_STROBE = s_ff.sample;
   assign INPUT_SETTLING = s_ff.settling;
   assign OUTPUT_WORD_VALID_N = s_ff.word_valid_n;
   assign CAL_BUSY = s_ff.busy;
   assign ZERO_STEP_ACTIVE = s_ff.zero_active;
   assign FS_STEP_ACTIVE = s_ff.fs_active;
   assign ZERO_REF_IS_AIN = s_ff.zero_ain;
   assign FS_REF_IS_AIN = s_ff.fs_ain;
   assign MIDSCALE_CAL = s_ff.midscale;
   assign ZERO_COEF_VALID = s_ff.zero_valid;
   assign FS_COEF_VALID = s_ff.fs_valid;
   assign ZERO_COEF_FROM_AIN = s_ff.zero_from_ain;
   assign FS_COEF_FROM_AIN = s_ff.fs_from_ain;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   property p_sample_period;
      SAMPLE_STROBE |=> !SAMPLE_STROBE ##254 !SAMPLE_STROBE ##1 SAMPLE_STROBE;
   endproperty
   a_sample_period: assert property (p_sample_period)
      else $error("Sample strobe not every 256 clocks");
   property p_settle;
      SAMPLE_STROBE |-> INPUT_SETTLING ##61 INPUT_SETTLING ##1 !INPUT_SETTLING;
   endproperty
   a_settle: assert property (p_settle)
      else $error("Settling window not 62 clocks");
   property p_self_len;
      cal_start && sel_type == adc_cal_pkg::CAL_SELF |=>
         s_ff.cnt == SELF_LD && ZERO_STEP_ACTIVE && FS_STEP_ACTIVE;
   endproperty
   a_self_len: assert property (p_self_len)
      else $error("Self-cal load wrong");
   property p_offset_len;
      cal_start && sel_type == adc_cal_pkg::CAL_SYS_OFFSET |=>
         s_ff.cnt == OFFSET_LD && ZERO_REF_IS_AIN && !FS_STEP_ACTIVE;
   endproperty
   a_offset_len: assert property (p_offset_len)
      else $error("Offset step load wrong");
   property p_gain_len;
      cal_start && sel_type == adc_cal_pkg::CAL_SYS_GAIN |=>
         s_ff.cnt == GAIN_LD && FS_REF_IS_AIN && !ZERO_STEP_ACTIVE;
   endproperty
   a_gain_len: assert property (p_gain_len)
      else $error("Gain step load wrong");
   property p_one_len;
      cal_start && sel_type == adc_cal_pkg::CAL_SYS_ONE |=>
         s_ff.cnt == ONE_LD && ZERO_REF_IS_AIN && !FS_REF_IS_AIN;
   endproperty
   a_one_len: assert property (p_one_len)
      else $error("One-step offset load wrong");
   property p_self_refs;
      CAL_BUSY && s_ff.cal_type == adc_cal_pkg::CAL_SELF |->
         !ZERO_REF_IS_AIN && !FS_REF_IS_AIN;
   endproperty
   a_self_refs: assert property (p_self_refs)
      else $error("Self-cal routed to input");
   property p_midscale;
      MIDSCALE_CAL |-> ZERO_STEP_ACTIVE && $past(BIPOLAR_MODE);
   endproperty
   a_midscale: assert property (p_midscale)
      else $error("Midscale trim outside bipolar zero step");
   property p_coef;
      cal_done && !cal_start &&
         s_ff.cal_type == adc_cal_pkg::CAL_SYS_OFFSET |=>
         ZERO_COEF_VALID && ZERO_COEF_FROM_AIN;
   endproperty
   a_coef: assert property (p_coef)
      else $error("Offset coefficient not stored");
   property p_busy_high;
      CAL_BUSY |-> OUTPUT_WORD_VALID_N;
   endproperty
   a_busy_high: assert property (p_busy_high)
      else $error("Word-valid low during calibration");
   property p_sys_fall;
      cal_done && !cal_start &&
         s_ff.cal_type != adc_cal_pkg::CAL_SELF |=>
         !OUTPUT_WORD_VALID_N && !CAL_BUSY;
   endproperty
   a_sys_fall: assert property (p_sys_fall)
      else $error("Word-valid did not fall after system step");
   property p_self_settle;
      cal_done && !cal_start &&
         s_ff.cal_type == adc_cal_pkg::CAL_SELF |=>
         s_ff.state == adc_cal_pkg::ST_SETTLE && OUTPUT_WORD_VALID_N;
   endproperty
   a_self_settle: assert property (p_self_settle)
      else $error("Self-cal skipped settling");
   c_self: cover property (cal_done &&
      s_ff.cal_type == adc_cal_pkg::CAL_SELF);
   c_offset: cover property (cal_done &&
      s_ff.cal_type == adc_cal_pkg::CAL_SYS_OFFSET);
   c_gain: cover property (cal_done &&
      s_ff.cal_type == adc_cal_pkg::CAL_SYS_GAIN);
   c_restart: cover property (cal_start && CAL_BUSY);

endmodule

`default_nettype wire

// [cal_host_model.sv]
// Host controller model driving the calibration strobe and type selects
`timescale 1ns/10ps
`default_nettype none

module cal_host_model (
   // Clock
   input wire logic clk,
   // Command from the bench
   input wire logic go,
   input wire logic [1:0] code,
   input wire logic [3:0] hold,
   // Calibration control toward the device
   output logic strobe,
   output logic sel_a,
   output logic sel_b,
   // Status back to the bench
   output logic idle
);
   logic [3:0] left;

   initial begin
      strobe = 1'b0;
      sel_a = 1'b0;
      sel_b = 1'b0;
      idle = 1'b1;
      left = 4'h0;
   end

   // -------------------------------------------------------------
   // Strobe generation
   // -------------------------------------------------------------
   // selects set with strobe
   always @(posedge clk) begin
      if (go && idle) begin
         sel_a <= code[1];
         sel_b <= code[0];
         strobe <= 1'b1;
         left <= hold;
         idle <= 1'b0;
      end else if (!idle) begin
         if (left > 4'h1) begin
            left <= left - 4'h1;
         end else begin
            strobe <= 1'b0; // Selects stay put past the fall
            idle <= 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

// [test_adc_calibration_sequencer.sv]
// Testbench for the calibration and sampling sequencer
`timescale 1ns/10ps
`default_nettype none

module test_adc_calibration_sequencer;
   localparam int SELF_N = 40;
   localparam int OFF_N = 20;
   localparam int GAIN_N = 24;
   localparam int ONE_N = 30;
   localparam int SETTLE_N = 16;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bip_mode = 1'b0;
   logic go = 1'b0;
   logic [1:0] code = 2'h0;
   logic [3:0] hold = 4'h4;
   logic strobe, sel_a, sel_b, idle;
   logic samp, settling, valid_n, busy, zero_step, fs_step;
   logic zero_ain, fs_ain, midscale, zero_ok, fs_ok, zero_from, fs_from;
   int fail_count = 0;
   int n_compared = 0;
   int cnt;

   // -------------------------------------------------------------
   // Instances
   // -------------------------------------------------------------
   cal_host_model cal_host_model_inst (.clk(clk), .go(go), .code(code),
      .hold(hold), .strobe(strobe), .sel_a(sel_a), .sel_b(sel_b),
      .idle(idle));

   adc_calibration_sequencer #(.SELF_CAL_CYC(SELF_N),
      .SYS_OFFSET_CYC(OFF_N), .SYS_GAIN_CYC(GAIN_N),
      .SYS_ONE_STEP_CYC(ONE_N), .FILTER_SETTLE_CYC(SETTLE_N)
   ) adc_calibration_sequencer_inst (.CLK(clk), .RST(rst),
      .CAL_STROBE(strobe), .TRIM_TYPE_SELECT_A(sel_a),
      .TRIM_TYPE_SELECT_B(sel_b), .BIPOLAR_MODE(bip_mode),
      .SAMPLE_STROBE(samp), .INPUT_SETTLING(settling),
      .OUTPUT_WORD_VALID_N(valid_n), .CAL_BUSY(busy),
      .ZERO_STEP_ACTIVE(zero_step), .FS_STEP_ACTIVE(fs_step),
      .ZERO_REF_IS_AIN(zero_ain), .FS_REF_IS_AIN(fs_ain),
      .MIDSCALE_CAL(midscale), .ZERO_COEF_VALID(zero_ok),
      .FS_COEF_VALID(fs_ok), .ZERO_COEF_FROM_AIN(zero_from),
      .FS_COEF_FROM_AIN(fs_from));

   // Clock, 8 ns period
   always #4 clk = ~clk;

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got,
            exp);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Issue one strobe and measure the busy span
   task automatic do_cal(input logic [1:0] c, input logic bip,
      input logic z_ain, input logic f_ain, input logic [1:0] stp,
      input logic chk_stp, input logic [3:0] len, output int n);
      int k;
      k = 0;
      n = 0;
      // Wait until the host model has finished any earlier strobe
      while (idle !== 1'b1) @(negedge clk);
      @(posedge clk);
      code <= c;
      bip_mode <= bip;
      hold <= len;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      while (busy !== 1'b1 && k < 40) begin
         @(negedge clk);
         k++;
      end
      check(busy, 1'b1);
      check(zero_ain, z_ain);
      check(fs_ain, f_ain);
      check(midscale, bip);
      if (chk_stp) check({zero_step, fs_step}, stp);
      while (busy === 1'b1 && n < 200) begin
         check(valid_n, 1'b1);
         n++;
         @(negedge clk);
      end
      check(valid_n, 1'b0);
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_reset();
      @(negedge clk);
      check({valid_n, busy, zero_ok, fs_ok}, 4'h8);
   endtask

   task automatic t_sample();
      int per;
      int hi;
      per = 0;
      hi = 0;
      while (samp !== 1'b1 && per < 300) begin
         @(negedge clk);
         per++;
      end
      per = 0;
      do begin
         if (settling === 1'b1) hi++;
         @(negedge clk);
         per++;
      end while (samp !== 1'b1 && per < 300);
      check(per, 256);
      check(hi, 62);
   endtask

   task automatic t_short();
      @(posedge clk);
      hold <= 4'h3;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (20) @(negedge clk);
      check(busy, 1'b0);
   endtask

   task automatic t_self();
      do_cal(2'h0, 1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 4'h4, cnt);
      check(cnt, SELF_N + SETTLE_N);
      check({zero_ok, fs_ok, zero_from, fs_from}, 4'hc);
   endtask

   task automatic t_offset();
      do_cal(2'h3, 1'b1, 1'b1, 1'b0, 2'h2, 1'b1, 4'h5, cnt);
      check(cnt, OFF_N);
      check({zero_from, fs_from}, 2'h2);
   endtask

   task automatic t_gain();
      do_cal(2'h1, 1'b0, 1'b0, 1'b1, 2'h1, 1'b1, 4'h4, cnt);
      check(cnt, GAIN_N);
      check({zero_from, fs_from}, 2'h3);
   endtask

   task automatic t_one();
      do_cal(2'h2, 1'b0, 1'b1, 1'b0, 2'h3, 1'b1, 4'h4, cnt);
      check(cnt, ONE_N);
      check({zero_from, fs_from}, 2'h2);
   endtask

   // -------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_sample();
      t_short();
      t_self();
      t_offset();
      t_gain();
      t_one();
      end_sim();
   end

   // Cut a hang short
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_sim();
   end
endmodule

`default_nettype wire
